// file: core/gdpf_defines.svh
// constants for the pin function block
`ifndef GDPF_DEFINES_SVH
`define GDPF_DEFINES_SVH
`define GDPF_NPINS 15
`define GDPF_PIN_MAG 0
`define GDPF_PIN_GNSS 1
`define GDPF_PIN_PRESS 2
`define GDPF_PIN_ZERO 3
`define GDPF_PIN_STATE 4
`define GDPF_PIN_RAW 5
`define GDPF_PIN_EV1 6
`define GDPF_PIN_EV2 7
`define GDPF_PIN_PPS 8
`define GDPF_PIN_WHEEL 9
`define GDPF_PIN_WENC_A 10
`define GDPF_PIN_WENC_B 11
`define GDPF_PIN_GENC_A 12
`define GDPF_PIN_GENC_B 13
`define GDPF_PIN_DIR 14
`define GDPF_FN_PASS 15
`define GDPF_FN_PROTO_IN 16
`define GDPF_FN_PROTO_OUT 17
`define GDPF_FN_ALT_OUT 18
`define GDPF_NFN 19
`define GDPF_ID_STATE 8'h14
`define GDPF_ID_RAW 8'h1C
`define GDPF_ID_PASS 8'h0A
`define GDPF_CRC_INIT 16'hFFFF
`define GDPF_CRC_POLY 16'h1021
`define GDPF_W8 4'h1
`define GDPF_W16 4'h2
`define GDPF_W32 4'h4
`define GDPF_W64 4'h8
`define GDPF_CLK_NS 50
`define GDPF_MS_NS 1000000
`define GDPF_MS_CYCLES (`GDPF_MS_NS / `GDPF_CLK_NS)
`define GDPF_ALT_MAX_HZ 50
`define GDPF_ALT_MIN_MS (1000 / `GDPF_ALT_MAX_HZ)
`define GDPF_GIMBAL_CPR 16'h1000
`endif

// file: core/gdpf_pkg.sv
// types for the pin function block
`default_nettype none
package gdpf_pkg;
  typedef enum logic [3:0] {
    GDPF_U8, GDPF_S8, GDPF_U16, GDPF_S16, GDPF_U32,
    GDPF_S32, GDPF_U64, GDPF_S64, GDPF_FP32, GDPF_FP64
  } gdpf_field_t;
  typedef enum logic [1:0] {
    GDPF_SER_IDLE = 2'b01,
    GDPF_SER_SEND = 2'b10
  } gdpf_ser_t;
endpackage
`default_nettype wire

// file: core/gdpf_pin_functions.sv
// pin function logic: disables, triggers, events, encoders, serializer
`default_nettype none
`include "gdpf_defines.svh"
// Contract
// - magnetometer disable pin: low uses magnetometers, high stops them
// - receiver disable pin: low uses internal receiver, high disables it
// - pressure disable pin: low uses pressure sensor, high ignores it
// - zero-align rising edge makes current orientation the zero offset
// - pin alignment volatile, lost on reset unless host writes permanent
// - state trigger rising edge requests one system state packet
// - raw trigger rising edge requests one raw sensors packet
// - switches on trigger inputs are debounced outside the device
// - event rising edge latches flag, cleared after next packet output
// - time pulse input rising edge gives the timing reference
// - protocol output sends only packets requested via protocol input
// - wheel speed input counts each high pulse as one trigger
// - wheel encoder phases decoded together as quadrature pair
// - gimbal encoder phases decoded into gimbal azimuth angle
// - direction input valid only with wheel speed, marks reverse
// - passthrough forwards host bytes out, returns received bytes
// - alternative serial outputs run at most at 50 Hz
// - multi-byte protocol fields go least significant byte first
// - field widths 1, 2, 4 or 8 bytes by type
// - checksum CCITT, starts all ones, covers data bytes only
module gdpf_pin_functions
  import gdpf_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `GDPF_MS_CYCLES
) (
  input  wire logic                   mclk,          // 20 MHz clock
  input  wire logic                   reset,         // sync, active high
  input  wire logic [`GDPF_NPINS-1:0] pin_in,        // asynchronous pins
  input  wire logic [`GDPF_NFN-1:0]   fn_sel,        // function enables
  input  wire logic                   dir_fwd_high,  // direction polarity
  input  wire logic [15:0]            cur_orient,    // present orientation
  input  wire logic                   align_wr,      // host alignment write
  input  wire logic                   align_perm,    // permanent flag
  input  wire logic [15:0]            align_val,     // host alignment value
  input  wire logic                   host_req_valid, // protocol request
  input  wire logic [7:0]             host_req_id,   // requested packet id
  input  wire logic                   pkt_req_ready, // packet engine ready
  input  wire logic                   pkt_done,      // packet output done
  input  wire logic                   pt_tx_valid,   // host passthrough byte
  input  wire logic [7:0]             pt_tx_byte,    // its data
  input  wire logic                   pt_rx_valid,   // byte from port
  input  wire logic [7:0]             pt_rx_byte,    // its data
  input  wire logic [15:0]            alt_period_ms, // alt output period
  input  wire logic                   fld_valid,     // field to serialize
  input  wire gdpf_field_t            fld_type,      // field type
  input  wire logic [63:0]            fld_value,     // field value
  input  wire logic                   crc_clear,     // start new payload
  input  wire logic                   ser_ready,     // byte sink ready
  output logic                        mag_off_q,     // magnetometers unused
  output logic                        gnss_off_q,    // receiver disabled
  output logic                        press_off_q,   // pressure ignored
  output logic [15:0]                 align_q,       // alignment offset
  output logic                        nv_wr_q,       // store alignment
  output logic                        pkt_req_valid_q, // packet request
  output logic [7:0]                  pkt_req_id_q,  // its packet id
  output logic                        ev1_q,         // event 1 flag
  output logic                        ev2_q,         // event 2 flag
  output logic                        pps_tick_q,    // time reference pulse
  output logic [31:0]                 wheel_cnt_q,   // signed pulse count
  output logic                        reverse_q,     // travel reversed
  output logic [31:0]                 wenc_cnt_q,    // wheel encoder count
  output logic [15:0]                 gimbal_az_q,   // gimbal azimuth counts
  output logic                        pt_out_valid_q, // byte to port
  output logic [7:0]                  pt_out_byte_q, // its data
  output logic                        pt_host_valid_q, // byte back to host
  output logic [7:0]                  pt_host_byte_q, // its data
  output logic                        alt_tick_q,    // alt output send
  output logic                        fld_ready_q,   // serializer free
  output logic                        ser_valid_q,   // serialized byte
  output logic [7:0]                  ser_byte_q,    // its data
  output logic [15:0]                 crc_q          // running checksum
);

  typedef struct packed {
    logic [`GDPF_NPINS-1:0] sync1;
    logic [`GDPF_NPINS-1:0] sync2;
    logic [`GDPF_NPINS-1:0] prev;
    logic        mag_off;
    logic        gnss_off;
    logic        press_off;
    logic [15:0] align;
    logic        nv_wr;
    logic        pend_state;
    logic        pend_raw;
    logic        pend_host;
    logic [7:0]  host_id;
    logic        req_valid;
    logic [7:0]  req_id;
    logic        ev1;
    logic        ev2;
    logic        pps_tick;
    logic [31:0] wheel_cnt;
    logic        reverse;
    logic [31:0] wenc_cnt;
    logic [15:0] gimbal_az;
    logic        pt_out_valid;
    logic [7:0]  pt_out_byte;
    logic        pt_host_valid;
    logic [7:0]  pt_host_byte;
    logic [15:0] ms_cnt;
    logic [15:0] alt_ms;
    logic        alt_tick;
    gdpf_ser_t   ser_st;
    logic [63:0] ser_sh;
    logic [3:0]  ser_left;
    logic        fld_ready;
    logic        ser_valid;
    logic [7:0]  ser_byte;
    logic [15:0] crc;
  } gdpf_state_t;

  gdpf_state_t s_q;
  gdpf_state_t s_d;

  // quadrature step: 2'b01 forward, 2'b11 backward, 2'b00 none or glitch
  function automatic logic [1:0] gdpf_quad(input logic [1:0] p,
                                           input logic [1:0] c);
    logic [3:0] t;
    t = {p, c};
    case (t)
      4'b0001, 4'b0111, 4'b1110, 4'b1000: gdpf_quad = 2'b01;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: gdpf_quad = 2'b11;
      default: gdpf_quad = 2'b00;
    endcase
  endfunction

  function automatic logic [3:0] gdpf_width(input gdpf_field_t t);
    case (t)
      GDPF_U8, GDPF_S8:             gdpf_width = `GDPF_W8;
      GDPF_U16, GDPF_S16:           gdpf_width = `GDPF_W16;
      GDPF_U32, GDPF_S32, GDPF_FP32: gdpf_width = `GDPF_W32;
      default:                      gdpf_width = `GDPF_W64;
    endcase
  endfunction

  function automatic logic [15:0] gdpf_crc8(input logic [15:0] c,
                                            input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ `GDPF_CRC_POLY) : (r << 1);
    end
    gdpf_crc8 = r;
  endfunction

  logic [`GDPF_NPINS-1:0] lvl;
  logic [`GDPF_NPINS-1:0] rise;
  logic [1:0]             wq;
  logic [1:0]             gq;
  logic [15:0]            alt_per;
  logic                   ser_adv;

  assign lvl  = s_q.sync2 & fn_sel[`GDPF_NPINS-1:0];
  assign rise = s_q.sync2 & ~s_q.prev & fn_sel[`GDPF_NPINS-1:0];
  assign wq = gdpf_quad({s_q.prev[`GDPF_PIN_WENC_A],
                         s_q.prev[`GDPF_PIN_WENC_B]},
                        {lvl[`GDPF_PIN_WENC_A], lvl[`GDPF_PIN_WENC_B]});
  assign gq = gdpf_quad({s_q.prev[`GDPF_PIN_GENC_A],
                         s_q.prev[`GDPF_PIN_GENC_B]},
                        {lvl[`GDPF_PIN_GENC_A], lvl[`GDPF_PIN_GENC_B]});
  // a period shorter than the rate ceiling is stretched, never refused
  assign alt_per = (alt_period_ms < 16'(`GDPF_ALT_MIN_MS)) ?
                   16'(`GDPF_ALT_MIN_MS) : alt_period_ms;
  assign ser_adv = !s_q.ser_valid || ser_ready;

  always_comb begin
    s_d = s_q;
    s_d.sync1 = pin_in;
    s_d.sync2 = s_q.sync1;
    s_d.prev  = s_q.sync2;
    s_d.mag_off   = lvl[`GDPF_PIN_MAG];
    s_d.gnss_off  = lvl[`GDPF_PIN_GNSS];
    s_d.press_off = lvl[`GDPF_PIN_PRESS];
    s_d.nv_wr = 1'b0;
    if (align_wr) begin
      s_d.align = align_val;
      s_d.nv_wr = align_perm;
    end else if (rise[`GDPF_PIN_ZERO]) begin
      s_d.align = cur_orient;
    end
    // triggers coalesce while their request is still pending
    if (rise[`GDPF_PIN_STATE]) s_d.pend_state = 1'b1;
    if (rise[`GDPF_PIN_RAW]) s_d.pend_raw = 1'b1;
    if (host_req_valid && fn_sel[`GDPF_FN_PROTO_IN] && !s_q.pend_host) begin
      s_d.pend_host = 1'b1;
      s_d.host_id   = host_req_id;
    end
    if (s_q.req_valid && pkt_req_ready) s_d.req_valid = 1'b0;
    if (!s_q.req_valid || pkt_req_ready) begin
      if (s_q.pend_state) begin
        s_d.req_valid  = 1'b1;
        s_d.req_id     = `GDPF_ID_STATE;
        s_d.pend_state = rise[`GDPF_PIN_STATE];
      end else if (s_q.pend_raw) begin
        s_d.req_valid = 1'b1;
        s_d.req_id    = `GDPF_ID_RAW;
        s_d.pend_raw  = rise[`GDPF_PIN_RAW];
      end else if (s_q.pend_host && fn_sel[`GDPF_FN_PROTO_OUT]) begin
        s_d.req_valid = 1'b1;
        s_d.req_id    = s_q.host_id;
        s_d.pend_host = 1'b0;
      end
    end
    // set wins over the clear by packet completion
    s_d.ev1 = (s_q.ev1 && !pkt_done) || rise[`GDPF_PIN_EV1];
    s_d.ev2 = (s_q.ev2 && !pkt_done) || rise[`GDPF_PIN_EV2];
    s_d.pps_tick = rise[`GDPF_PIN_PPS];
    s_d.reverse = lvl[`GDPF_PIN_DIR] & fn_sel[`GDPF_PIN_WHEEL] ? !dir_fwd_high
                : fn_sel[`GDPF_PIN_DIR] & fn_sel[`GDPF_PIN_WHEEL] &
                  dir_fwd_high;
    if (rise[`GDPF_PIN_WHEEL]) begin
      s_d.wheel_cnt = s_q.reverse ? s_q.wheel_cnt - 32'h0000_0001
                                  : s_q.wheel_cnt + 32'h0000_0001;
    end
    if (fn_sel[`GDPF_PIN_WENC_A] && fn_sel[`GDPF_PIN_WENC_B]) begin
      s_d.wenc_cnt = s_q.wenc_cnt + {{30{wq[1]}}, wq};
    end
    if (fn_sel[`GDPF_PIN_GENC_A] && fn_sel[`GDPF_PIN_GENC_B]) begin
      if (gq == 2'b01) begin
        s_d.gimbal_az = (s_q.gimbal_az == `GDPF_GIMBAL_CPR - 16'h0001) ?
                        16'h0000 : s_q.gimbal_az + 16'h0001;
      end else if (gq == 2'b11) begin
        s_d.gimbal_az = (s_q.gimbal_az == 16'h0000) ?
                        `GDPF_GIMBAL_CPR - 16'h0001
                        : s_q.gimbal_az - 16'h0001;
      end
    end
    // no buffer: a byte is held one cycle, the link side paces it
    s_d.pt_out_valid  = pt_tx_valid && fn_sel[`GDPF_FN_PASS];
    s_d.pt_out_byte   = pt_tx_byte;
    s_d.pt_host_valid = pt_rx_valid && fn_sel[`GDPF_FN_PASS];
    s_d.pt_host_byte  = pt_rx_byte;
    s_d.alt_tick = 1'b0;
    if (!fn_sel[`GDPF_FN_ALT_OUT]) begin
      s_d.ms_cnt = 16'h0000;
      s_d.alt_ms = 16'h0000;
    end else if (32'(s_q.ms_cnt) == MS_CYCLES - 1) begin
      s_d.ms_cnt = 16'h0000;
      if (s_q.alt_ms + 16'h0001 >= alt_per) begin
        s_d.alt_ms   = 16'h0000;
        s_d.alt_tick = 1'b1;
      end else begin
        s_d.alt_ms = s_q.alt_ms + 16'h0001;
      end
    end else begin
      s_d.ms_cnt = s_q.ms_cnt + 16'h0001;
    end
    if (crc_clear) s_d.crc = `GDPF_CRC_INIT;
    if (s_q.ser_valid && ser_ready) s_d.ser_valid = 1'b0;
    case (s_q.ser_st)
      GDPF_SER_IDLE: begin
        if (fld_valid && s_q.fld_ready) begin
          s_d.ser_sh    = fld_value;
          s_d.ser_left  = gdpf_width(fld_type);
          s_d.ser_st    = GDPF_SER_SEND;
          s_d.fld_ready = 1'b0;
        end
      end
      GDPF_SER_SEND: begin
        if (ser_adv && s_q.ser_left != 4'h0) begin
          s_d.ser_valid = 1'b1;
          s_d.ser_byte  = s_q.ser_sh[7:0];
          s_d.ser_sh    = {8'h00, s_q.ser_sh[63:8]};
          s_d.ser_left  = s_q.ser_left - 4'h1;
          s_d.crc = gdpf_crc8(crc_clear ? `GDPF_CRC_INIT : s_q.crc,
                              s_q.ser_sh[7:0]);
        end else if (s_q.ser_left == 4'h0) begin
          s_d.ser_st    = GDPF_SER_IDLE;
          s_d.fld_ready = 1'b1;
        end
      end
      default: begin
        s_d.ser_st    = GDPF_SER_IDLE;
        s_d.fld_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_q           <= '0;
      s_q.ser_st    <= GDPF_SER_IDLE;
      s_q.fld_ready <= 1'b1;
      s_q.crc       <= `GDPF_CRC_INIT;
    end else begin
      s_q <= s_d;
    end
  end

  assign mag_off_q       = s_q.mag_off;
  assign gnss_off_q      = s_q.gnss_off;
  assign press_off_q     = s_q.press_off;
  assign align_q         = s_q.align;
  assign nv_wr_q         = s_q.nv_wr;
  assign pkt_req_valid_q = s_q.req_valid;
  assign pkt_req_id_q    = s_q.req_id;
  assign ev1_q           = s_q.ev1;
  assign ev2_q           = s_q.ev2;
  assign pps_tick_q      = s_q.pps_tick;
  assign wheel_cnt_q     = s_q.wheel_cnt;
  assign reverse_q       = s_q.reverse;
  assign wenc_cnt_q      = s_q.wenc_cnt;
  assign gimbal_az_q     = s_q.gimbal_az;
  assign pt_out_valid_q  = s_q.pt_out_valid;
  assign pt_out_byte_q   = s_q.pt_out_byte;
  assign pt_host_valid_q = s_q.pt_host_valid;
  assign pt_host_byte_q  = s_q.pt_host_byte;
  assign alt_tick_q      = s_q.alt_tick;
  assign fld_ready_q     = s_q.fld_ready;
  assign ser_valid_q     = s_q.ser_valid;
  assign ser_byte_q      = s_q.ser_byte;
  assign crc_q           = s_q.crc;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_sync_delay;
    ##3 (s_q.sync2 == $past(pin_in, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("pin not seen two cycles later");

  // the select is applied at the last flop, the pin three flops back
  property p_mag_off;
    ##3 (mag_off_q == ($past(pin_in[`GDPF_PIN_MAG], 3) &
                       $past(fn_sel[`GDPF_PIN_MAG])));
  endproperty
  a_mag_off: assert property (p_mag_off)
    else $error("magnetometer disable not following pin");

  property p_zero;
    (rise[`GDPF_PIN_ZERO] && !align_wr) |=> align_q == $past(cur_orient);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero alignment did not take orientation");

  property p_perm;
    align_wr |=> (nv_wr_q == $past(align_perm)) ##1 !nv_wr_q;
  endproperty
  a_perm: assert property (p_perm)
    else $error("permanent store pulse wrong");

  property p_state_req;
    (rise[`GDPF_PIN_STATE] && !s_q.pend_state && !s_q.req_valid &&
     !s_q.pend_raw && !s_q.pend_host) |=>
      ##1 (pkt_req_valid_q && pkt_req_id_q == `GDPF_ID_STATE);
  endproperty
  a_state_req: assert property (p_state_req)
    else $error("state packet not requested");

  property p_event;
    rise[`GDPF_PIN_EV1] |=> ev1_q;
  endproperty
  a_event: assert property (p_event)
    else $error("event flag not latched");

  property p_event_clr;
    (ev1_q && pkt_done && !rise[`GDPF_PIN_EV1]) |=> !ev1_q;
  endproperty
  a_event_clr: assert property (p_event_clr)
    else $error("event flag not cleared after packet");

  property p_pps;
    rise[`GDPF_PIN_PPS] |=> pps_tick_q ##1 !pps_tick_q;
  endproperty
  a_pps: assert property (p_pps)
    else $error("time pulse tick not single");

  property p_wheel;
    (rise[`GDPF_PIN_WHEEL] && !reverse_q) |=>
      wheel_cnt_q == $past(wheel_cnt_q) + 32'h0000_0001;
  endproperty
  a_wheel: assert property (p_wheel)
    else $error("wheel pulse not counted");

  property p_alt_rate;
    alt_tick_q |-> $past(s_q.alt_ms) >= 16'(`GDPF_ALT_MIN_MS - 1);
  endproperty
  a_alt_rate: assert property (p_alt_rate)
    else $error("alternative output faster than ceiling");

  property p_crc_init;
    (crc_clear && s_q.ser_st == GDPF_SER_IDLE) |=> crc_q == `GDPF_CRC_INIT;
  endproperty
  a_crc_init: assert property (p_crc_init)
    else $error("checksum not started from all ones");

  property p_lsb_first;
    (s_q.ser_st == GDPF_SER_SEND && ser_adv && s_q.ser_left != 4'h0) |=>
      ser_valid_q && ser_byte_q == $past(s_q.ser_sh[7:0]);
  endproperty
  a_lsb_first: assert property (p_lsb_first)
    else $error("byte order not least significant first");

endmodule
`default_nettype wire

// file: verif/gdpf_far_model.sv
// far-side model: byte sink and packet engine, both stalling
`default_nettype none
module gdpf_far_model (
  input  wire logic       mclk,      // core clock
  input  wire logic       reset,     // sync, active high
  input  wire logic       ser_valid, // byte offered
  input  wire logic [7:0] ser_byte,  // its data
  input  wire logic       req_valid, // packet request
  input  wire logic [7:0] req_id,    // requested id
  output var  logic       ser_ready = 1'b0, // sink accepts
  output var  logic       req_ready = 1'b0  // engine accepts
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  bq[$];
  logic [7:0]  pq[$];
  logic [15:0] lfsr = 16'hace1;
  // pseudo-random stalls so the hold-until-ready paths get exercised
  always @(posedge mclk) begin
    lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    ser_ready <= !reset && lfsr[0];
    req_ready <= !reset && lfsr[3];
    if (ser_valid && ser_ready) bq.push_back(ser_byte);
    if (req_valid && req_ready) pq.push_back(req_id);
  end
endmodule
`default_nettype wire

// file: verif/gdpf_pin_functions_tb_top.sv
// self-checking bench for the pin function block
`default_nettype none
module gdpf_pin_functions_tb_top
  import gdpf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 0, reset = 1, dfh = 0, awr = 0, aperm = 0;
  logic        hrv = 0, pkd = 0, ptv = 0, prv = 0, fv = 0, cclr = 0;
  logic [14:0] pin = 0;
  logic [18:0] fn = 0;
  logic [15:0] orient = 0, aval = 0, aper = 0, c, o;
  logic [7:0]  hid = 0, ptb = 0, prb = 0, b;
  logic [63:0] fval = 0;
  logic [31:0] seed = 32'hb743;
  logic [1:0]  ph = 0;
  gdpf_field_t ftype = GDPF_U8;
  logic mag, gnss, press, nvwr, rqv, ev1, ev2, pps, rev, pov, phv, alt;
  logic frdy, sv, srdy, rrdy;
  logic [15:0] align, gaz, crc;
  logic [7:0]  rqid, pob, phb, sb;
  logic [31:0] wcnt, ecnt;
  int          mismatches = 0, cmp_count = 0, pps_n = 0, n, b0;

  gdpf_pin_functions #(.MS_CYCLES(20)) uut (
    .mclk(mclk), .reset(reset), .pin_in(pin), .fn_sel(fn),
    .dir_fwd_high(dfh), .cur_orient(orient), .align_wr(awr),
    .align_perm(aperm), .align_val(aval), .host_req_valid(hrv),
    .host_req_id(hid), .pkt_req_ready(rrdy), .pkt_done(pkd),
    .pt_tx_valid(ptv), .pt_tx_byte(ptb), .pt_rx_valid(prv),
    .pt_rx_byte(prb), .alt_period_ms(aper), .fld_valid(fv),
    .fld_type(ftype), .fld_value(fval), .crc_clear(cclr),
    .ser_ready(srdy), .mag_off_q(mag), .gnss_off_q(gnss),
    .press_off_q(press), .align_q(align), .nv_wr_q(nvwr),
    .pkt_req_valid_q(rqv), .pkt_req_id_q(rqid), .ev1_q(ev1), .ev2_q(ev2),
    .pps_tick_q(pps), .wheel_cnt_q(wcnt), .reverse_q(rev),
    .wenc_cnt_q(ecnt), .gimbal_az_q(gaz), .pt_out_valid_q(pov),
    .pt_out_byte_q(pob), .pt_host_valid_q(phv), .pt_host_byte_q(phb),
    .alt_tick_q(alt), .fld_ready_q(frdy), .ser_valid_q(sv),
    .ser_byte_q(sb), .crc_q(crc));
  gdpf_far_model far (.mclk(mclk), .reset(reset), .ser_valid(sv),
    .ser_byte(sb), .req_valid(rqv), .req_id(rqid), .ser_ready(srdy),
    .req_ready(rrdy));

  initial forever #25 mclk = ~mclk;
  // counted mid-cycle, away from the edge that launches the pulse
  always @(negedge mclk) if (pps) pps_n <= pps_n + 1;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] crcb(logic [15:0] x, logic [7:0] d);
    x ^= {d, 8'h00};
    for (int i = 0; i < 8; i++) x = x[15] ? (x << 1) ^ 16'h1021 : x << 1;
    return x;
  endfunction
  function automatic int wid(int k);
    return k < 2 ? 1 : k < 4 ? 2 : (k < 6 || k == 8) ? 4 : 8;
  endfunction

  task tick(int k);
    repeat (k) @(negedge mclk);
  endtask
  task chk(logic [63:0] g, logic [63:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task results;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // clean single edges: the switch is taken as already debounced
  task pulse(int i);
    pin[i] = 1;
    tick(4);
    pin[i] = 0;
    tick(4);
  endtask
  task waitq(int np, int nb);
    for (int k = 0; k < 300 && (far.pq.size() < np || far.bq.size() < nb);
         k++) tick(1);
    if (far.pq.size() < np || far.bq.size() < nb) begin
      chk(far.pq.size(), np);
      chk(far.bq.size(), nb);
      results();
    end
  endtask
  task rst;
    reset = 1;
    tick(2);
    chk({mag, gnss, press, nvwr, rqv, ev1, ev2, pps, rev, frdy, crc},
        {9'h000, 1'b1, 16'hffff});
    chk(align, 0);
    reset = 0;
  endtask
  task quad(int a, int d);
    for (int k = 0; k < 8; k++) begin
      ph = ph + d;
      {pin[a+1], pin[a]} = ph ^ {1'b0, ph[1]};
      tick(4);
    end
  endtask

  initial begin
    rst();
    fn = 19'h00007;
    for (int i = 0; i < 3; i++) begin
      pin[i] = 1;
      tick(4);
      chk({press, gnss, mag}, 1 << i);
      pin[i] = 0;
      tick(4);
      chk({press, gnss, mag}, 0);
    end
    fn = 19'h00008;
    pin[0] = 1;
    tick(4);
    chk(mag, 0);
    pin[0] = 0;
    orient = xs();
    o = orient;
    pulse(3);
    chk(align, o);
    orient = ~o;
    tick(4);
    chk(align, o);
    awr = 1;
    aperm = 1;
    aval = xs();
    tick(1);
    awr = 0;
    chk(nvwr, 1);
    chk(align, aval);
    rst();
    fn = 19'h000c0;
    for (int i = 0; i < 2; i++) begin
      pulse(6 + i);
      chk({ev2, ev1}, 1 << i);
      pkd = 1;
      tick(1);
      pkd = 0;
      tick(2);
      chk({ev2, ev1}, 0);
    end
    fn = 19'h00100;
    repeat (3) pulse(8);
    chk(pps_n, 3);
    fn = 19'h04200;
    dfh = 1;
    pin[14] = 1;
    // let the direction level settle before the first wheel edge
    tick(4);
    n = 1 + xs() % 6;
    repeat (n) pulse(9);
    chk(wcnt, n);
    chk(rev, 0);
    pin[14] = 0;
    tick(4);
    chk(rev, 1);
    pulse(9);
    chk(wcnt, n - 1);
    fn = 19'h03c00;
    tick(4);
    chk(rev, 0);
    quad(10, 1);
    quad(12, 1);
    chk(ecnt == 0, 0);
    chk(gaz == 0, 0);
    quad(12, -1);
    quad(10, -1);
    chk(ecnt, 0);
    chk(gaz, 0);
    fn = 19'h08000;
    for (int i = 0; i < 2; i++) begin
      b = xs();
      // received side carries a survey receiver packet id
      if (i == 1) b = 8'h40;
      {ptv, prv, ptb, prb} = {i == 0, i == 1, b, b};
      tick(1);
      {ptv, prv} = 0;
      chk(i ? {phv, phb} : {pov, pob}, {1'b1, b});
    end
    fn = 19'h10030;
    hrv = 1;
    hid = 8'h25;
    tick(1);
    hrv = 0;
    tick(6);
    chk(rqv, 0);
    fn[17] = 1;
    waitq(1, 0);
    chk(far.pq[0], 8'h25);
    pulse(4);
    pulse(5);
    waitq(3, 0);
    chk(far.pq[1], 8'h14);
    chk(far.pq[2], 8'h1c);
    fn = 19'h40000;
    aper = 16'h0005;
    for (int k = 0; k < 1000 && !alt; k++) tick(1);
    chk(alt, 1);
    tick(1);
    for (n = 1; n < 1000 && !alt; n++) tick(1);
    chk(n, 400);
    for (int k = 0; k < 10; k++) begin
      cclr = 1;
      tick(1);
      cclr = 0;
      ftype = gdpf_field_t'(k);
      fval = {xs(), xs()};
      c = 16'hffff;
      b0 = far.bq.size();
      chk(frdy, 1);
      fv = 1;
      tick(1);
      fv = 0;
      waitq(0, b0 + wid(k));
      tick(4);
      for (int j = 0; j < wid(k); j++) begin
        c = crcb(c, fval[8*j+:8]);
        chk(far.bq[b0+j], fval[8*j+:8]);
      end
      chk(far.bq.size(), b0 + wid(k));
      chk(crc, c);
    end
    results();
  end
endmodule
`default_nettype wire
